/* dv/spi_host_model.sv */
module spi_host_model (
   // Clock
   input wire logic mclk_i,
   // Link pins
   output logic cs_n_o,
   output logic sck_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins start at valid levels, never floating
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end

   // Mode 0 frame, MSB first; reply sampled late in the high phase
   task automatic frame(input logic [31:0] data, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge mclk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      for (int i = nbits - 1; i >= 0; i--) begin
         sdi_o <= data[i];
         // Fixed 400 ns period keeps sck under the low-power limit
         repeat (4) @(posedge mclk_i);
         sck_o <= 1'b1;
         repeat (3) @(posedge mclk_i);
         @(negedge mclk_i);
         // Undriven reply line floats high on the device's pull-up
         rx = {rx[6:0], sdo_oe_i ? sdo_i : 1'b1};
         @(posedge mclk_i);
         sck_o <= 1'b0;
      end
      repeat (4) @(posedge mclk_i);
      cs_n_o <= 1'b1;
      // Released data line shows the inverse, not a stale value
      sdi_o <= ~sdi_o;
      // Sync plus registered mode change settle well inside this gap
      repeat (12) @(posedge mclk_i);
   endtask
endmodule

/* dv/tb.sv */
module tb import eeprom_pm_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [31:0] data;
      logic [5:0] nbits;
      logic [3:0] exp;
   } row_t;

   logic mclk, rst_n, deep_exit, slow_seen;
   logic [7:0] rx;
   wire logic cs_n, sck, sdi, sdo, sdo_oe, write_latch, deepest_sleep, power_down;
   wire logic idle_sleep, lean_standby, standby, write_busy, osc_slow;
   wire logic idle_en, lean_en, saw_en, thr_en;
   int n_fail = 0;
   int num_checks = 0;

   // Expected {latch, power_down, deepest, standby} after each command
   localparam row_t ROWS [10] = '{
      '{32'h06, 6'h08, 4'h9}, '{32'h04, 6'h08, 4'h1}, '{32'h06, 6'h08, 4'h9},
      '{32'h4A, 6'h0C, 4'h9}, '{32'hA1, 6'h08, 4'h4}, '{32'h06, 6'h08, 4'h4},
      '{32'hA2, 6'h08, 4'h1}, '{32'hA3, 6'h08, 4'h2}, '{32'h06, 6'h08, 4'h2},
      '{32'hA2, 6'h08, 4'h2}};

   spi_host_model host (.mclk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo),
                        .sdo_oe_i(sdo_oe));

   eeprom_power_ctrl dut (
      .mclk_i(mclk), .rst_n_i(rst_n), .spi_cs_n_i(cs_n), .spi_sck_i(sck),
      .spi_sdi_i(sdi), .deep_exit_i(deep_exit), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
      .write_latch_o(write_latch), .deepest_sleep_o(deepest_sleep),
      .power_down_o(power_down), .idle_sleep_o(idle_sleep),
      .lean_standby_o(lean_standby), .standby_o(standby), .write_busy_o(write_busy),
      .osc_slow_o(osc_slow), .idle_sleep_en_o(idle_en), .lean_standby_en_o(lean_en),
      .sleep_after_write_en_o(saw_en), .throttled_oscillator_en_o(thr_en));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Bounded wait for the self-timed write, noting any slowed interval
   task automatic wait_write();
      int k;
      k = 0;
      slow_seen = 1'b0;
      while (write_busy !== 1'b0 && k < 4000) begin
         @(negedge mclk);
         if (osc_slow === 1'b1) slow_seen = 1'b1;
         k++;
      end
      check(32'(k < 4000), 32'h1);
      repeat (8) @(posedge mclk);
   endtask

   task automatic exit_deep();
      @(posedge mclk);
      deep_exit <= 1'b1;
      repeat (6) @(posedge mclk);
      deep_exit <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask

   // Watchdog: whole run needs roughly 11k cycles
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      deep_exit = 1'b0;
      slow_seen = 1'b0;
      repeat (12) @(posedge mclk);
      check({write_latch, standby}, 2'h1);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      foreach (ROWS[i]) begin
         host.frame(ROWS[i].data, int'(ROWS[i].nbits), rx);
         check({write_latch, power_down, deepest_sleep, standby}, ROWS[i].exp);
      end
      exit_deep();
      check({write_latch, power_down, deepest_sleep, standby}, 4'h1);
      host.frame(32'h0500, 16, rx);
      check(rx, 8'h00);
      host.frame(32'h06, 8, rx);
      host.frame(32'h0500, 16, rx);
      check(rx, 8'h02);
      // Status one write turns on idle sleep and lean standby
      host.frame(32'h0160, 16, rx);
      check(write_busy, 1'b1);
      wait_write();
      check({idle_en, lean_en, write_latch, idle_sleep, lean_standby}, 5'h1A);
      // Page clear and full clear need the latch and clear it when done
      host.frame(32'h06, 8, rx);
      host.frame(32'hA40000, 24, rx);
      check(write_busy, 1'b1);
      wait_write();
      check({write_latch, deepest_sleep, write_busy}, 3'h0);
      host.frame(32'h06, 8, rx);
      host.frame(32'hA5, 8, rx);
      check(write_busy, 1'b1);
      wait_write();
      check({write_latch, deepest_sleep, write_busy}, 3'h0);
      // Status two write must not end in deepest sleep
      host.frame(32'h06, 8, rx);
      host.frame(32'h3103, 16, rx);
      wait_write();
      check({saw_en, thr_en, deepest_sleep, write_latch}, 4'hC);
      // Throttled array write ends in deepest sleep
      host.frame(32'h06, 8, rx);
      host.frame(32'h0200005A, 32, rx);
      wait_write();
      check({slow_seen, deepest_sleep, write_latch}, 3'h6);
      // Status fetch in deepest sleep is ignored; only the pull-up answers
      host.frame(32'h0500, 16, rx);
      check(rx, 8'hFF);
      check(deepest_sleep, 1'b1);
      exit_deep();
      // Write without the latch is refused
      host.frame(32'h0200005A, 32, rx);
      check(write_busy, 1'b0);
      // Commanded power-down under idle sleep takes the wake command only
      host.frame(32'hA1, 8, rx);
      host.frame(32'h06, 8, rx);
      check({power_down, write_latch}, 2'h2);
      host.frame(32'hA2, 8, rx);
      check({power_down, idle_sleep}, 2'h1);
      // Status one write with lean standby only, sleep-after-write still on
      host.frame(32'h06, 8, rx);
      host.frame(32'h0120, 16, rx);
      wait_write();
      check(deepest_sleep, 1'b1);
      exit_deep();
      check({idle_sleep, lean_standby, standby}, 3'h2);
      stop_test();
   end
endmodule

/* rtl/eeprom_pm_pkg.sv */
// Operation
// - Chip select high and no write running: sit in standby awaiting commands.
// - Power-down command moves the device from standby into power-down.
// - In power-down only the wake command is obeyed; all else ignored.
// - Deepest-sleep command enters deepest sleep, shutting extra circuitry.
// - In deepest sleep every command is ignored, status fetch and wake included.
// - Status byte one reports deepest-sleep flag; reading it never wakes.
// - Only the dedicated exit pin sequence leaves deepest sleep.
// - Sleep-after-write enabled: array or status-one write completion enters deepest sleep.
// - Status-two write completion never enters deepest sleep.
// - Idle-sleep enabled: idle means power-down; chip select fall wakes normally.
// - Power-down command under idle-sleep is true power-down, woken only by wake.
// - Lean standby enabled: idle means low-power standby; select fall leaves it.
// - Power-down command under lean standby is true power-down, wake command only.
// - Throttling enabled: writes alternate fast and slow oscillator intervals.
// - Latch cleared at power-up; writes, erases, status writes refused without it.
// - Latch-set command 06h sets the write latch.
// - Latch clears after successful latch clear, writes, erases and power-down.
// - Select rising mid-byte makes the command fail; latch left unchanged.
// - Latch-clear command 04h clears the latch regardless of write protect.
// - Status two: bit 0 sleep-after-write, bit 1 throttling, both volatile.
// - Status one: idle-sleep bit 6, lean-standby bit 5, deepest-sleep flag bit 4.
package eeprom_pm_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // Self-timed write length; plain default, not a device figure
   localparam int WRITE_TIME_NS = 50000;
   localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] WRITE_LAST = 11'(WRITE_CYCLES - 1);
   localparam logic [1:0] SLOW_DIV_LAST = 2'h3;
   // Known opcodes
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_STATUS1_FETCH = 8'h05;
   localparam logic [7:0] OP_STATUS1_UPDATE = 8'h01;
   localparam logic [7:0] OP_STATUS2_UPDATE = 8'h31;
   localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
   // Defaults for opcodes not fixed here; arbitrary values
   localparam logic [7:0] OP_POWER_DOWN_DEF = 8'hA1;
   localparam logic [7:0] OP_WAKE_DEF = 8'hA2;
   localparam logic [7:0] OP_DEEPEST_DEF = 8'hA3;
   localparam logic [7:0] OP_PAGE_CLEAR_DEF = 8'hA4;
   localparam logic [7:0] OP_FULL_CLEAR_DEF = 8'hA5;
   // Byte counts framing each command
   localparam logic [2:0] STATUS_WRITE_BYTES = 3'h2;
   localparam logic [2:0] ARRAY_WRITE_MIN_BYTES = 3'h4;
   localparam logic [2:0] PAGE_CLEAR_BYTES = 3'h3;
   localparam logic [2:0] FULL_CLEAR_BYTES = 3'h1;
   // Status field positions
   localparam int S1_BUSY_BIT = 0;
   localparam int S1_LATCH_BIT = 1;
   localparam int S1_DEEP_BIT = 4;
   localparam int S1_LEAN_BIT = 5;
   localparam int S1_IDLE_BIT = 6;
   localparam int S2_AFTER_WRITE_BIT = 0;
   localparam int S2_THROTTLE_BIT = 1;
   // Values after reset
   localparam logic IDLE_SLEEP_RST = 1'b0;
   localparam logic LEAN_STANDBY_RST = 1'b0;
   typedef enum logic [3:0] {
      MODE_IDLE = 4'b0001,
      MODE_PD = 4'b0010,
      MODE_DEEP = 4'b0100,
      MODE_BUSY = 4'b1000
   } mode_t;
endpackage

/* rtl/eeprom_power_ctrl.sv */
module eeprom_power_ctrl
   import eeprom_pm_pkg::*;
#(
   parameter logic [7:0] POWER_DOWN_OP = OP_POWER_DOWN_DEF,
   parameter logic [7:0] WAKE_OP = OP_WAKE_DEF,
   parameter logic [7:0] DEEPEST_OP = OP_DEEPEST_DEF,
   parameter logic [7:0] PAGE_CLEAR_OP = OP_PAGE_CLEAR_DEF,
   parameter logic [7:0] FULL_CLEAR_OP = OP_FULL_CLEAR_DEF
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Serial link pins and the deepest-sleep exit pin
   input wire logic spi_cs_n_i,
   input wire logic spi_sck_i,
   input wire logic spi_sdi_i,
   input wire logic deep_exit_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   // Power and latch state
   output logic write_latch_o,
   output logic deepest_sleep_o,
   output logic power_down_o,
   output logic idle_sleep_o,
   output logic lean_standby_o,
   output logic standby_o,
   output logic write_busy_o,
   output logic osc_slow_o,
   // Configuration bits
   output logic idle_sleep_en_o,
   output logic lean_standby_en_o,
   output logic sleep_after_write_en_o,
   output logic throttled_oscillator_en_o
);
   logic [3:0] pin_raw, sync1, sync2;
   logic cs_d, sck_d, ext_d;
   logic [2:0] bit_cnt, byte_cnt;
   logic [6:0] shift_in;
   logic [7:0] opcode, data1, sdo_shift, status1;
   logic reading, deep_after;
   logic [10:0] timer;
   logic [5:0] phase_cnt;
   logic [1:0] div_cnt;
   mode_t mode, next_mode;

   // Pins pass two flops before use; the first stage feeds only the second
   assign pin_raw = {deep_exit_i, spi_sdi_i, spi_sck_i, spi_cs_n_i};
   for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            sync1[g] <= 1'b1;
            sync2[g] <= 1'b1;
         end else begin
            sync1[g] <= pin_raw[g];
            sync2[g] <= sync1[g];
         end
      end
   end

   // Edge detection on the synchronised pins
   wire cs_n = sync2[0];
   wire sck = sync2[1];
   wire sdi = sync2[2];
   wire ext = sync2[3];
   wire sck_rise = !cs_n && sck && !sck_d;
   wire sck_fall = !cs_n && !sck && sck_d;
   wire cs_rise = cs_n && !cs_d;
   wire ext_rise = ext && !ext_d;
   wire [7:0] in_byte = {shift_in, sdi};
   wire byte_end = sck_rise && (bit_cnt == 3'h7);

   // Whole-byte framing check, shared by the status, array, page clear and full clear writes
   function automatic logic framed(input logic [2:0] cnt, input logic [2:0] need,
                                   input logic exact);
      framed = exact ? (cnt == need) : (cnt >= need);
   endfunction

   // Command decode, evaluated when select rises on a byte boundary
   wire whole = (bit_cnt == 3'h0) && (byte_cnt != 3'h0);
   wire go = cs_rise && whole;
   wire in_idle = (mode == MODE_IDLE);
   wire in_pd = (mode == MODE_PD);
   wire is_set = go && in_idle && (opcode == OP_LATCH_SET);
   wire is_clr = go && in_idle && (opcode == OP_LATCH_CLEAR);
   wire is_pd = go && in_idle && (opcode == POWER_DOWN_OP);
   wire is_wake = go && in_pd && (opcode == WAKE_OP);
   wire is_deep = go && in_idle && (opcode == DEEPEST_OP);
   // Writes need the latch; without it they fall through to idle
   wire wr_ok = go && in_idle && write_latch_o;
   wire is_s1 = wr_ok && (opcode == OP_STATUS1_UPDATE)
                && framed(byte_cnt, STATUS_WRITE_BYTES, 1'b1);
   wire is_s2 = wr_ok && (opcode == OP_STATUS2_UPDATE)
                && framed(byte_cnt, STATUS_WRITE_BYTES, 1'b1);
   wire is_arr = wr_ok && (opcode == OP_ARRAY_WRITE)
                 && framed(byte_cnt, ARRAY_WRITE_MIN_BYTES, 1'b0);
   wire is_page = wr_ok && (opcode == PAGE_CLEAR_OP)
                  && framed(byte_cnt, PAGE_CLEAR_BYTES, 1'b1);
   wire is_full = wr_ok && (opcode == FULL_CLEAR_OP)
                  && framed(byte_cnt, FULL_CLEAR_BYTES, 1'b1);
   wire start_busy = is_s1 || is_s2 || is_arr || is_page || is_full;
   // Status fetch allowed when awake or writing, never in any sleep
   wire fetch = byte_end && (byte_cnt == 3'h0) && (in_idle || mode == MODE_BUSY)
                && (in_byte == OP_STATUS1_FETCH);

   // Throttled oscillator: slow half of each phase ticks one in four
   wire slow_phase = throttled_oscillator_en_o && phase_cnt[5];
   wire tick = !slow_phase || (div_cnt == SLOW_DIV_LAST);
   wire busy_done = (mode == MODE_BUSY) && tick && (timer == WRITE_LAST);

   // Idle flavour follows the enables; select low means active
   wire idle_next = (next_mode == MODE_IDLE) && cs_n;

   // Status byte one image
   always_comb begin
      status1 = 8'h00;
      status1[S1_BUSY_BIT] = (mode == MODE_BUSY);
      status1[S1_LATCH_BIT] = write_latch_o;
      status1[S1_DEEP_BIT] = (mode == MODE_DEEP);
      status1[S1_LEAN_BIT] = lean_standby_en_o;
      status1[S1_IDLE_BIT] = idle_sleep_en_o;
   end

   // Mode transitions
   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_IDLE: begin
            if (is_pd) next_mode = MODE_PD;
            else if (is_deep) next_mode = MODE_DEEP;
            else if (start_busy) next_mode = MODE_BUSY;
         end
         MODE_PD: begin
            // Select falling alone never wakes from a commanded power-down
            if (is_wake) next_mode = MODE_IDLE;
         end
         MODE_DEEP: begin
            if (ext_rise) next_mode = MODE_IDLE;
         end
         MODE_BUSY: begin
            if (busy_done) next_mode = deep_after ? MODE_DEEP : MODE_IDLE;
         end
         default: next_mode = MODE_IDLE;
      endcase
   end

   // Edge history; resets to the synchroniser's level so reset makes no false edge
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_d <= 1'b1;
         sck_d <= 1'b1;
         ext_d <= 1'b1;
      end else begin
         cs_d <= cs_n;
         sck_d <= sck;
         ext_d <= ext;
      end
   end

   // Serial input framing; counters restart with every select
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         shift_in <= 7'h00;
         opcode <= 8'h00;
         data1 <= 8'h00;
      end else if (cs_n) begin
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
      end else if (sck_rise) begin
         shift_in <= in_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_end && byte_cnt != 3'h7) byte_cnt <= byte_cnt + 3'h1;
         if (byte_end && byte_cnt == 3'h0) opcode <= in_byte;
         if (byte_end && byte_cnt == 3'h1) data1 <= in_byte;
      end
   end

   // Status fetch output; changes on falling clock, repeats while held
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reading <= 1'b0;
         sdo_shift <= 8'h00;
         spi_sdo_o <= 1'b0;
         spi_sdo_oe_o <= 1'b0;
      end else if (cs_n) begin
         reading <= 1'b0;
         spi_sdo_o <= 1'b0;
         spi_sdo_oe_o <= 1'b0;
      end else if (fetch) begin
         reading <= 1'b1;
         sdo_shift <= status1;
      end else if (sck_fall && reading) begin
         spi_sdo_o <= sdo_shift[7];
         spi_sdo_oe_o <= 1'b1;
         sdo_shift <= {sdo_shift[6:0], sdo_shift[7]};
      end
   end

   // Write latch; power-up clears it, failed commands leave it alone
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) write_latch_o <= 1'b0;
      else if (is_set) write_latch_o <= 1'b1;
      else if (is_clr || is_pd || busy_done) write_latch_o <= 1'b0;
   end

   // Configuration bits; status one reset value stands in for stored cells
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_sleep_en_o <= IDLE_SLEEP_RST;
         lean_standby_en_o <= LEAN_STANDBY_RST;
         sleep_after_write_en_o <= 1'b0;
         throttled_oscillator_en_o <= 1'b0;
      end else begin
         if (is_s1) begin
            idle_sleep_en_o <= data1[S1_IDLE_BIT];
            lean_standby_en_o <= data1[S1_LEAN_BIT];
         end
         if (is_s2) begin
            sleep_after_write_en_o <= data1[S2_AFTER_WRITE_BIT];
            throttled_oscillator_en_o <= data1[S2_THROTTLE_BIT];
         end
      end
   end

   // Self-timed write engine
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode <= MODE_IDLE;
         deep_after <= 1'b0;
         timer <= 11'h000;
         phase_cnt <= 6'h00;
         div_cnt <= 2'h0;
      end else begin
         mode <= next_mode;
         if (start_busy) begin
            // Status two writes never lead to deepest sleep
            deep_after <= sleep_after_write_en_o && (is_arr || is_s1);
            timer <= 11'h000;
            phase_cnt <= 6'h00;
            div_cnt <= 2'h0;
         end else if (mode == MODE_BUSY) begin
            phase_cnt <= phase_cnt + 6'h01;
            div_cnt <= slow_phase ? div_cnt + 2'h1 : 2'h0;
            if (tick) timer <= timer + 11'h001;
         end
      end
   end

   // Registered power state outputs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         deepest_sleep_o <= 1'b0;
         power_down_o <= 1'b0;
         idle_sleep_o <= 1'b0;
         lean_standby_o <= 1'b0;
         standby_o <= 1'b1;
         write_busy_o <= 1'b0;
         osc_slow_o <= 1'b0;
      end else begin
         deepest_sleep_o <= (next_mode == MODE_DEEP);
         power_down_o <= (next_mode == MODE_PD);
         idle_sleep_o <= idle_next && idle_sleep_en_o;
         lean_standby_o <= idle_next && lean_standby_en_o && !idle_sleep_en_o;
         standby_o <= idle_next && !lean_standby_en_o && !idle_sleep_en_o;
         write_busy_o <= (next_mode == MODE_BUSY);
         osc_slow_o <= (mode == MODE_BUSY) && slow_phase;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   latch_set_a: assert property (is_set |=> write_latch_o)
      else $error("latch not set by set command");
   latch_clear_a: assert property (is_clr |=> !write_latch_o)
      else $error("latch not cleared by clear command");
   pd_entry_a: assert property (is_pd |=> power_down_o && !write_latch_o)
      else $error("power-down command not obeyed");
   pd_ignore_a: assert property (in_pd && !is_wake |=> power_down_o)
      else $error("power-down left without wake command");
   deep_hold_a: assert property ((mode == MODE_DEEP) && !ext_rise |=> deepest_sleep_o)
      else $error("deepest sleep left without exit sequence");
   deep_entry_a: assert property ($rose(deepest_sleep_o) |-> $past(is_deep) || $past(busy_done))
      else $error("deepest sleep entered without cause");
   auto_deep_a: assert property (busy_done && deep_after |=> deepest_sleep_o)
      else $error("no deepest sleep after write");
   status2_deep_a: assert property (is_s2 |=> !deep_after)
      else $error("status two write armed deepest sleep");
   refuse_write_a: assert property (go && in_idle && !write_latch_o |=> !write_busy_o)
      else $error("write started without latch");
   // A write finishing in the same cycle may still clear the latch legally
   partial_byte_a: assert property (cs_rise && bit_cnt != 3'h0 && !busy_done
                                    |=> $stable(write_latch_o))
      else $error("latch changed by partial command");
   busy_hold_a: assert property (start_busy |=> write_busy_o [*8])
      else $error("write cycle ended too early");
   standby_idle_a: assert property (cs_n && cs_d && in_idle && !ext_rise && !idle_sleep_en_o
                                    && !lean_standby_en_o |=> standby_o)
      else $error("not in standby while idle");
   // Select low always wakes from the idle flavours
   idle_wake_a: assert property (!cs_n && in_idle
                                 |=> !idle_sleep_o && !lean_standby_o && !standby_o)
      else $error("idle state kept while selected");

   arr_write_c: cover property (is_arr);
   auto_deep_c: cover property (busy_done && deep_after);
   wake_c: cover property (is_wake);
   deep_exit_c: cover property (ext_rise && mode == MODE_DEEP);
endmodule
